// ==== design/dspfw_memmap.sv ====
// Firmware memory decoder with the shared X-data store of cores 2 and 3
module dspfw_memmap
  import dspfw_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                rst_i,
  // Register access, host or any core through the external arbiter
  input  wire logic                req_i,
  input  wire logic                we_i,
  input  wire logic [ADDR_W-1:0]   addr_i,
  input  wire logic [DATA_W-1:0]   wdata_i,
  output logic                     busy_o,
  output logic                     ack_o,
  output logic [DATA_W-1:0]        rdata_o,
  // Memory enables, one per core
  input  wire logic [CORES-1:0]    core_memory_power_on_i,
  output logic [CORES-1:0]         mem_clear_o,
  // Private firmware memories, 80-bit word pairs with byte enables
  output logic                     mem_req_o,
  output logic                     mem_we_o,
  output logic [2:0]               mem_core_o,
  output logic [1:0]               mem_kind_o,
  output logic [IDX_W-1:0]         mem_index_o,
  output logic [BE_W-1:0]          mem_be_o,
  output logic [PAIR_W-1:0]        mem_wdata_o,
  input  wire logic [PAIR_W-1:0]   mem_rdata_i,
  // Shared X ports of core 2 and core 3
  input  wire logic                sha_we_i,
  input  wire logic [SH_W-1:0]     sha_addr_i,
  input  wire logic [WORD_W-1:0]   sha_wdata_i,
  output logic [WORD_W-1:0]        sha_rdata_o,
  input  wire logic                shb_we_i,
  input  wire logic [SH_W-1:0]     shb_addr_i,
  input  wire logic [WORD_W-1:0]   shb_wdata_i,
  output logic [WORD_W-1:0]        shb_rdata_o,
  // Collision report
  output logic [SH_W-1:0]          shared_write_clash_location_o,
  output logic                     clash_event_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_CAPT} dspfw_st_e;

  dspfw_st_e state_q, state_d;
  logic [WORD_W-1:0] shmem [0:(1<<SH_W)-1];

  // Request decode
  wire [2:0]       blk    = addr_i[21:19];
  wire [2:0]       core   = blk - 3'h1;
  wire [1:0]       kind   = addr_i[18:17];
  wire [IDX_W-1:0] rix    = addr_i[16:1];
  wire             even   = ~addr_i[0];
  wire [15:0]      limit  = LIMIT[{core, kind}];
  wire             in_rng = (blk != 3'h0) && even && (rix < limit);
  wire             pwr    = core_memory_power_on_i[core];
  wire             sh_on  = core_memory_power_on_i[SH_CORE_A]
                          | core_memory_power_on_i[SH_CORE_B];
  wire             sh_hit = ((core == SH_CORE_A) || (core == SH_CORE_B))
                          && (blk != 3'h0) && even && (kind == KIND_XDATA)
                          && (rix[15:12] == SH_PAGE) && sh_on;
  wire             ext_hit = in_rng && pwr;
  wire             take    = req_i && (state_q == ST_IDLE);

  // Program packing: register r is part r mod 3 of pair r div 3
  wire [15:0] pair = rix / REGS_PER_PAIR;
  wire [15:0] sub  = rix - 16'(pair * REGS_PER_PAIR);
  wire        prog = (kind == KIND_PROG);
  wire [IDX_W-1:0] widx = prog ? {pair[14:0], 1'b0} : rix;
  wire [BE_W-1:0]  be   = !prog         ? BE_DATA :
                          (sub == 16'h0) ? BE_SUB0 :
                          (sub == 16'h1) ? BE_SUB1 : BE_SUB2;
  // Replication puts each part on its lane; byte enables pick one
  wire [PAIR_W-1:0] wrep = {wdata_i[15:0], wdata_i, wdata_i};

  // Latched access
  logic            we_q, ext_q, sh_q, prog_q;
  logic [1:0]      sub_q;
  logic [SH_W-1:0] shidx_q;
  logic [WORD_W-1:0] shw_q, sh_rd_q;

  // Shared store arbitration: core ports first, host waits its turn
  logic [SH_W-1:0] wipe_q;
  wire  wipe     = ~sh_on;
  wire  a_we     = sha_we_i && sh_on;
  wire  b_we     = shb_we_i && sh_on;
  wire  clash    = a_we && b_we && (sha_addr_i == shb_addr_i);
  wire  host_shw = (state_q == ST_ISSUE) && sh_q && we_q
                 && !a_we && !b_we && !wipe;
  wire  sh_stall = (state_q == ST_ISSUE) && sh_q && we_q && !host_shw;

  wire [31:0] prog_rd = (sub_q == 2'h0) ? mem_rdata_i[31:0] :
                        (sub_q == 2'h1) ? mem_rdata_i[63:32] :
                        {16'h0000, mem_rdata_i[79:64]};
  wire [31:0] ext_rd  = prog_q ? prog_rd : {8'h00, mem_rdata_i[23:0]};
  wire [31:0] rd_sel  = we_q  ? 32'h0000_0000 :
                        ext_q ? ext_rd :
                        sh_q  ? {8'h00, sh_rd_q} : 32'h0000_0000;

  // Three-cycle turn on the system clock alone, longer while a host shared write waits
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:  if (take) state_d = ST_ISSUE;
      ST_ISSUE: if (!sh_stall) state_d = ST_CAPT;
      ST_CAPT:  state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      busy_o  <= 1'b0;
      ack_o   <= 1'b0;
      rdata_o <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      busy_o  <= (state_d != ST_IDLE);
      ack_o   <= (state_q == ST_CAPT);
      if (state_q == ST_CAPT) rdata_o <= rd_sel;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      we_q <= 1'b0;
      ext_q <= 1'b0;
      sh_q <= 1'b0;
      prog_q <= 1'b0;
      sub_q <= 2'h0;
      shidx_q <= '0;
      shw_q <= '0;
    end else if (take) begin
      we_q <= we_i;
      ext_q <= ext_hit;
      sh_q <= sh_hit;
      prog_q <= prog;
      sub_q <= sub[1:0];
      shidx_q <= rix[SH_W-1:0];
      shw_q <= wdata_i[WORD_W-1:0];
    end
  end

  // External memory request, one cycle, only for a mapped powered word
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_core_o <= 3'h0;
      mem_kind_o <= KIND_PROG;
      mem_index_o <= '0;
      mem_be_o <= '0;
      mem_wdata_o <= '0;
    end else begin
      mem_req_o <= take && ext_hit;
      if (take) begin
        mem_we_o <= we_i;
        mem_core_o <= core;
        mem_kind_o <= kind;
        mem_index_o <= widx;
        mem_be_o <= be;
        mem_wdata_o <= wrep;
      end
    end
  end

  // Power-off clears are held for as long as the enable stays low
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mem_clear_o <= {CORES{1'b1}};
      wipe_q <= '0;
      shared_write_clash_location_o <= '0;
      clash_event_o <= 1'b0;
    end else begin
      mem_clear_o <= ~core_memory_power_on_i;
      wipe_q <= wipe ? wipe_q + 12'h001 : '0;
      clash_event_o <= clash;
      if (clash) shared_write_clash_location_o <= sha_addr_i;
    end
  end

  // Shared store; on a clash core 3 writes last and keeps the word
  always_ff @(posedge clk_sys_i) begin
    if (wipe) shmem[wipe_q] <= '0;
    if (a_we) shmem[sha_addr_i] <= sha_wdata_i;
    if (b_we) shmem[shb_addr_i] <= shb_wdata_i;
    if (host_shw) shmem[shidx_q] <= shw_q;
    sh_rd_q <= shmem[shidx_q];
    sha_rdata_o <= shmem[sha_addr_i];
    shb_rdata_o <= shmem[shb_addr_i];
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  AST_ACK_TURN: assert property (
    take && !sh_hit |-> ##3 ack_o)
    else $error("access not answered three cycles after it was taken");

  AST_UNMAPPED_ZERO: assert property (
    take && !we_i && !ext_hit && !sh_hit |-> ##1 !mem_req_o ##2
      (ack_o && rdata_o == 32'h0000_0000))
    else $error("unmapped read did not return zero");

  AST_POWER_GATE: assert property (
    take && !pwr |-> ##1 !mem_req_o)
    else $error("memory reached while its power enable was low");

  AST_PROG_PACK: assert property (
    take && ext_hit && prog && rix == 16'h0005 |-> ##1
      mem_req_o && mem_index_o == 16'h0002 && mem_be_o == BE_SUB2)
    else $error("program register 5 not mapped to pair 1 high part");

  AST_CORE1_RANGE: assert property (
    take && addr_i == 22'h086000 |-> ##1 !mem_req_o)
    else $error("address past core 1 program memory was decoded");

  AST_ALIAS: assert property (
    take && sh_on && (addr_i == 22'h136000 || addr_i == 22'h1b6000)
      |-> sh_hit && rix[SH_W-1:0] == 12'h000)
    else $error("shared alias did not reach shared word zero");

  AST_CLASH_EVT: assert property (
    clash |=> clash_event_o
      && shared_write_clash_location_o == $past(sha_addr_i))
    else $error("collision not reported with its word offset");

  AST_NO_CLASH: assert property (
    !clash |=> !clash_event_o && $stable(shared_write_clash_location_o))
    else $error("collision event without a collision");
endmodule

// ==== design/dspfw_pkg.sv ====
// Constants for the DSP firmware memory map decoder
package dspfw_pkg;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 32;
  localparam int WORD_W = 24;
  localparam int PAIR_W = 80;
  localparam int BE_W   = 10;
  localparam int CORES  = 7;
  localparam int IDX_W  = 16;
  localparam int SH_W   = 12;

  // Memory kind field, address bits 18:17 inside a core block
  localparam logic [1:0] KIND_PROG  = 2'h0;
  localparam logic [1:0] KIND_XDATA = 2'h1;
  localparam logic [1:0] KIND_YDATA = 2'h2;
  localparam logic [1:0] KIND_COEF  = 2'h3;

  // Shared X area: register index b000..bfff of the X map of both cores
  localparam logic [3:0] SH_PAGE   = 4'hb;
  localparam logic [2:0] SH_CORE_A = 3'h1;
  localparam logic [2:0] SH_CORE_B = 3'h2;

  // Two 40-bit program words take three 32-bit registers
  localparam logic [15:0] REGS_PER_PAIR = 16'h0003;
  localparam logic [9:0]  BE_SUB0 = 10'h00f;
  localparam logic [9:0]  BE_SUB1 = 10'h0f0;
  localparam logic [9:0]  BE_SUB2 = 10'h300;
  localparam logic [9:0]  BE_DATA = 10'h007;

  // Register counts per core: program, X, Y, coefficient
  localparam logic [15:0] LIMIT [0:27] = '{
    16'h3000, 16'h4000, 16'h1000, 16'h1000,
    16'h7800, 16'h6000, 16'h6000, 16'h1000,
    16'h7800, 16'h9000, 16'h6000, 16'h1000,
    16'h4800, 16'h9000, 16'h6000, 16'h1000,
    16'h4800, 16'h5000, 16'h2000, 16'h1000,
    16'h3000, 16'ha000, 16'h6000, 16'h1000,
    16'h4800, 16'h4000, 16'h1000, 16'h1000
  };

  // Core clock ceilings; this block itself never needs a core clock
  localparam int CORE_FAST_MHZ = 150;
  localparam int CORE_SLOW_MHZ = 75;
endpackage

// ==== test/dspfw_mem_model.sv ====
// Behavioural firmware memory behind the decoder, one-cycle read latency
module dspfw_mem_model
  import dspfw_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  // Request from the decoder
  input  wire logic              mem_req_i,
  input  wire logic              mem_we_i,
  input  wire logic [2:0]        mem_core_i,
  input  wire logic [1:0]        mem_kind_i,
  input  wire logic [IDX_W-1:0]  mem_index_i,
  input  wire logic [BE_W-1:0]   mem_be_i,
  input  wire logic [PAIR_W-1:0] mem_wdata_i,
  input  wire logic [CORES-1:0]  mem_clear_i,
  // Answer
  output logic      [PAIR_W-1:0] mem_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [PAIR_W-1:0] store [logic [20:0]];
  logic [20:0]       drop_q [$];
  logic [20:0]       key;
  assign key = {mem_core_i, mem_kind_i, mem_index_i};
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mem_rdata_o <= '0;
    end else begin
      // Stale data is inverted so a late sample cannot pass
      mem_rdata_o <= ~mem_rdata_o;
      if (mem_req_i && mem_we_i) begin
        if (!store.exists(key)) store[key] = '0;
        for (int b = 0; b < BE_W; b++)
          if (mem_be_i[b]) store[key][8*b +: 8] = mem_wdata_i[8*b +: 8];
      end else if (mem_req_i) begin
        mem_rdata_o <= store.exists(key) ? store[key] : '0;
      end
      // A core losing power loses its contents
      foreach (store[k])
        if (mem_clear_i[k[20:18]]) drop_q.push_back(k);
      foreach (drop_q[i]) store.delete(drop_q[i]);
      drop_q.delete();
    end
  end
endmodule

// ==== test/dspfw_memmap_tb.sv ====
// Self-checking bench for the firmware memory map decoder
module dspfw_memmap_tb
  import dspfw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i, rst_i, req_i, we_i, busy_o, ack_o, mem_req_o, mem_we_o;
  logic sha_we_i, shb_we_i, clash_event_o;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i, rdata_o;
  logic [CORES-1:0]  core_memory_power_on_i, mem_clear_o;
  logic [2:0] mem_core_o;
  logic [1:0] mem_kind_o;
  logic [IDX_W-1:0] mem_index_o;
  logic [BE_W-1:0] mem_be_o;
  logic [PAIR_W-1:0] mem_wdata_o, mem_rdata_i;
  logic [SH_W-1:0] sha_addr_i, shb_addr_i, shared_write_clash_location_o;
  logic [WORD_W-1:0] sha_wdata_i, shb_wdata_i, sha_rdata_o, shb_rdata_o;
  int n_errors, samples_checked;
  // Answer latency: three cycles unless a core write makes the host wait
  int exp_lat = 3;
  // Last register of a range, first beyond it; 1 data, 2 program part two
  localparam logic [21:0] DA [0:21] = '{22'h0a_7ffe, 22'h0a_8000,
    22'h0c_1ffe, 22'h0c_2000, 22'h0e_1ffe, 22'h08_5ffe, 22'h08_6000,
    22'h10_effe, 22'h10_f000, 22'h12_bffe, 22'h12_c000, 22'h13_8000,
    22'h14_bffe, 22'h16_1ffe, 22'h1b_1ffe, 22'h1b_2000, 22'h1c_bffe,
    22'h23_1ffe, 22'h23_2000, 22'h26_1ffe, 22'h28_8ffe, 22'h0a_0001};
  localparam logic [1:0] DM [0:21] = '{2'h1, 2'h0, 2'h1, 2'h0, 2'h1, 2'h2,
    2'h0, 2'h2, 2'h0, 2'h1, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h0, 2'h1, 2'h1,
    2'h0, 2'h1, 2'h2, 2'h0};

  dspfw_memmap dspfw_memmap_inst (.clk_sys_i, .rst_i, .req_i, .we_i,
    .addr_i, .wdata_i, .busy_o, .ack_o, .rdata_o, .core_memory_power_on_i,
    .mem_clear_o, .mem_req_o, .mem_we_o, .mem_core_o, .mem_kind_o,
    .mem_index_o, .mem_be_o, .mem_wdata_o, .mem_rdata_i, .sha_we_i,
    .sha_addr_i, .sha_wdata_i, .sha_rdata_o, .shb_we_i, .shb_addr_i,
    .shb_wdata_i, .shb_rdata_o, .shared_write_clash_location_o,
    .clash_event_o);
  dspfw_mem_model dspfw_mem_model_inst (.clk_sys_i, .rst_i,
    .mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_core_i(mem_core_o),
    .mem_kind_i(mem_kind_o), .mem_index_i(mem_index_o), .mem_be_i(mem_be_o),
    .mem_wdata_i(mem_wdata_o), .mem_clear_i(mem_clear_o),
    .mem_rdata_o(mem_rdata_i));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input string what, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    if (n_errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // One access; the request is a single-cycle pulse taken while idle
  task automatic acc(input logic w, input logic [21:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_sys_i);
    req_i <= 1'b1;
    we_i <= w;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    req_i <= 1'b0;
    n = 0;
    do begin
      @(negedge clk_sys_i);
      n++;
      if (n == 1) chk("busy", 32'h1, {31'h0, busy_o});
    end while (ack_o !== 1'b1 && n < 20);
    q = rdata_o;
    if (ack_o !== 1'b1) begin
      n_errors++;
      final_report();
    end else begin
      chk("ack latency", exp_lat, n);
      chk("busy end", 32'h0, {31'h0, busy_o});
    end
  endtask

  task automatic t_pack();
    logic [31:0] q;
    logic [PAIR_W-1:0] pr;
    acc(1'b1, 22'h08_0006, 32'h1122_3344, q);
    acc(1'b1, 22'h08_0008, 32'h5566_7788, q);
    acc(1'b1, 22'h08_000a, 32'hdead_beef, q);
    pr = dspfw_mem_model_inst.store[2];
    chk("pair mid", 32'h5566_7788, pr[63:32]);
    chk("pair top", 32'h0000_beef, {16'h0, pr[79:64]});
    acc(1'b0, 22'h08_0006, 32'h0, q);
    chk("part0", 32'h1122_3344, q);
    acc(1'b0, 22'h08_000a, 32'h0, q);
    chk("part2", 32'h0000_beef, q);
  endtask

  task automatic t_decode();
    logic [31:0] q, exp_d;
    for (int i = 0; i < 22; i++)
      acc(1'b1, DA[i], {8'hff, 2'h0, DA[i]}, q);
    for (int i = 0; i < 22; i++) begin
      acc(1'b0, DA[i], 32'h0, q);
      exp_d = {10'h0, DA[i]} & {8'h0, {8{DM[i][0]}}, {16{|DM[i]}}};
      chk("decode", exp_d, q);
    end
  endtask

  task automatic t_shared();
    logic [31:0] q;
    acc(1'b1, 22'h13_600a, 32'hffc0_ffee, q);
    acc(1'b0, 22'h1b_600a, 32'h0, q);
    chk("alias", 32'h00c0_ffee, q);
    acc(1'b1, 22'h1b_7ffe, 32'h0012_3456, q);
    acc(1'b0, 22'h13_7ffe, 32'h0, q);
    chk("alias top", 32'h0012_3456, q);
    acc(1'b1, 22'h1b_6000, 32'h00be_ef01, q);
    acc(1'b0, 22'h13_6000, 32'h0, q);
    chk("alias base", 32'h00be_ef01, q);
    @(posedge clk_sys_i);
    shb_addr_i <= 12'h005;
    sha_addr_i <= 12'hfff;
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk("core view", 32'h00c0_ffee, {8'h0, shb_rdata_o});
    chk("core view a", 32'h0012_3456, {8'h0, sha_rdata_o});
  endtask

  // Host write to the shared area waits one cycle behind a core write
  task automatic t_stall();
    logic [31:0] q;
    exp_lat = 4;
    fork
      acc(1'b1, 22'h13_6014, 32'h00ab_cdef, q);
      begin
        repeat (2) @(posedge clk_sys_i);
        sha_we_i <= 1'b1;
        @(posedge clk_sys_i);
        sha_we_i <= 1'b0;
      end
    join
    exp_lat = 3;
    acc(1'b0, 22'h1b_6014, 32'h0, q);
    chk("stalled write", 32'h00ab_cdef, q);
  endtask

  task automatic t_clash();
    logic [31:0] q;
    @(posedge clk_sys_i);
    sha_we_i <= 1'b1;
    shb_we_i <= 1'b1;
    sha_addr_i <= 12'h123;
    shb_addr_i <= 12'h124;
    @(posedge clk_sys_i);
    shb_addr_i <= 12'h123;
    @(negedge clk_sys_i);
    chk("no clash", 32'h0, {31'h0, clash_event_o});
    @(posedge clk_sys_i);
    sha_we_i <= 1'b0;
    shb_we_i <= 1'b0;
    @(negedge clk_sys_i);
    chk("clash", 32'h1, {31'h0, clash_event_o});
    chk("where", 32'h123, {20'h0, shared_write_clash_location_o});
    acc(1'b0, 22'h13_6246, 32'h0, q);
    chk("winner", 32'h0022_2222, q);
  endtask

  task automatic t_power();
    logic [31:0] q;
    acc(1'b1, 22'h0a_0000, 32'h0012_3456, q);
    @(posedge clk_sys_i);
    core_memory_power_on_i <= 7'h7e;
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk("clear", 32'h1, {31'h0, mem_clear_o[0]});
    acc(1'b0, 22'h0a_0000, 32'h0, q);
    chk("off read", 32'h0, q);
    @(posedge clk_sys_i);
    core_memory_power_on_i <= 7'h7f;
    acc(1'b0, 22'h0a_0000, 32'h0, q);
    chk("lost", 32'h0, q);
    // Cores 2 and 3 off: shared store unreachable, then swept to zero
    @(posedge clk_sys_i);
    core_memory_power_on_i <= 7'h79;
    acc(1'b0, 22'h13_600a, 32'h0, q);
    chk("shared off", 32'h0, q);
    repeat (4100) @(posedge clk_sys_i);
    core_memory_power_on_i <= 7'h7f;
    acc(1'b0, 22'h1b_600a, 32'h0, q);
    chk("shared wiped", 32'h0, q);
  endtask

  initial begin
    rst_i = 1'b1;
    {req_i, we_i, sha_we_i, shb_we_i} = 4'h0;
    addr_i = '0;
    wdata_i = '0;
    core_memory_power_on_i = 7'h7f;
    {sha_addr_i, shb_addr_i} = '0;
    sha_wdata_i = 24'h111111;
    shb_wdata_i = 24'h222222;
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_pack();
    t_decode();
    t_shared();
    t_clash();
    t_stall();
    t_power();
    final_report();
  end
endmodule
